// [design/ttm_regs.vh]
// Register offsets, field positions and timing constants for the thermal input timer monitor.
// Assumes an 8-bit register port with byte addresses as offsets.
`ifndef TTM_REGS_VH
`define TTM_REGS_VH
// ==========================================================
// Register offsets
`define TTM_OFS_MASK_TWO 8'h75
`define TTM_OFS_CONFIG_THREE 8'h78
`define TTM_OFS_TIMER 8'h79
`define TTM_OFS_LIMIT 8'h7A
`define TTM_OFS_CONFIG_FOUR 8'h7D
`define TTM_OFS_STATUS_TWO 8'h42
// ==========================================================
// Field positions
`define TTM_C3_ENABLE_BIT 1
`define TTM_C3_BOOST_BIT 2
`define TTM_C4_ALERT_BIT 0
`define TTM_C4_HIGHPIN_BIT 1
`define TTM_FLAG_BIT 5
// ==========================================================
// Reset value, full-scale value and the value one
`define TTM_RST_BYTE 8'h00
`define TTM_FULL_SCALE 8'hFF
`define TTM_ONE 8'h01
// ==========================================================
// Timing: timer LSB weight in microseconds, clock period in ns
`define TTM_LSB_US 22760
`define TTM_CLK_NS 100
`endif

// [design/ttm_sync.v]
// Two-flop synchroniser for one level input.
// Assumes the input is asynchronous to sys_clk.
`default_nettype none
module ttm_sync #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Level in and out
  input wire din,
  output reg dout
);
  reg meta_r;
  // ==========================================================
  // Sync chain
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // ttm_sync
`default_nettype wire

// [design/ttm_monitor.v]
// Thermal throttle input timer, limit compare, sticky flag, alert and fan boost.
// Assumes a simple synchronous 8-bit register port and raw active-low pins.
// Assumes one strobe per access: reads of the timer and status registers clear state.
// Limits: only the thermal limit event of status register two is modelled here.
// Limits: LSB_CYCLES sets the timer weight; the default suits the 100 ns clock.
// Limits: the tick counter restarts on a timer read, so a read drops a partial LSB.
// Trade-off: a tick sum held through pauses keeps pauses exact at the cost of a 32-bit counter.
//
// What this block does
// - Thermal function on one pin, chosen by select
// - Monitor only while enable bit set
// - Default pin thermal; alternate frees fourth tach while enable bit set
// - Alert-select bit routes alert to pin
// - Boost forces fans full while line low
// - Boost only affects fans already running
// - Boost off leaves fans at setting
// - Timer accumulates asserted time, pauses on negation
// - Timer saturates at full scale
// - Timer read returns value then clears
// - Bit0 on first assertion, then 22.76ms LSB
// - Read during assertion restarts with bit0 set
// - Zero limit re-sets flag after such read
// - Timer above limit sets flag and alert
// - Zero limit alerts on first assertion
// - Limit one alerts past 45.52 ms
// - Mask bit suppresses alert, flag still set
// - Flag clears only on read after condition gone
// - Alert output disabled out of reset
`include "ttm_regs.vh"
`default_nettype none
module ttm_monitor #(
  parameter LSB_CYCLES = (`TTM_LSB_US * 1000) / `TTM_CLK_NS,
  parameter FANS = 3
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Thermal pins, active low
  input wire thermal_throttle_line_pin_default_n,
  input wire thermal_throttle_line_pin_alt_n,
  // Fan duty and running state
  input wire [FANS*8-1:0] fan_duty_in,
  input wire [FANS-1:0] fan_auto_mode,
  input wire [FANS-1:0] fan_above_start,
  output reg [FANS*8-1:0] fan_duty_out,
  // Freed tach and alert
  output reg fourth_tach_input_en,
  output reg alert_out_n,
  output reg alert_out_en
);
  reg [7:0] mask_two_r;
  reg [7:0] config_three_r;
  reg [7:0] config_four_r;
  reg [7:0] limit_r;
  reg [7:0] timer_r;
  reg [7:0] timer_nxt;
  reg limit_exceeded_flag_r;
  reg [31:0] tick_r;
  reg [31:0] tick_nxt;
  reg seen_r;
  reg seen_nxt;
  // Next values, strobes and routing
  reg [7:0] mask_two_nxt;
  reg [7:0] config_three_nxt;
  reg [7:0] config_four_nxt;
  reg [7:0] limit_nxt;
  reg wrapped_r;
  reg wrapped_nxt;
  reg flag_nxt;
  reg [7:0] rdata_nxt;
  wire wr_mask;
  wire wr_config_three;
  wire wr_config_four;
  wire wr_limit;
  wire tick_last;
  wire boost_on;
  wire alert_req;
  wire [FANS-1:0] fan_running;

  wire sync_def_n;
  wire sync_alt_n;
  wire mon_en;
  wire high_sel;
  wire thermal_throttle_line;
  wire rd_timer;
  wire rd_status;
  wire over_limit;
  integer i;
  genvar g;

  // ==========================================================
  // Input synchronisers
  // Each pin has its own chain, so a pin switch sees a settled level
  ttm_sync #(.RST_VAL(1'b1)) u_sync_def (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din(thermal_throttle_line_pin_default_n),
    .dout(sync_def_n)
  );
  ttm_sync #(.RST_VAL(1'b1)) u_sync_alt (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .din(thermal_throttle_line_pin_alt_n),
    .dout(sync_alt_n)
  );

  // ==========================================================
  // Pin selection
  assign mon_en = config_three_r[`TTM_C3_ENABLE_BIT];
  assign high_sel = config_four_r[`TTM_C4_HIGHPIN_BIT];
  // Exactly one pin feeds the line; the other is ignored
  // Disabled monitoring forces the line idle, so nothing counts
  assign thermal_throttle_line = mon_en &
    (high_sel ? ~sync_alt_n : ~sync_def_n);
  assign rd_timer = reg_rd && (reg_addr == `TTM_OFS_TIMER);
  assign rd_status = reg_rd && (reg_addr == `TTM_OFS_STATUS_TWO);

  // ==========================================================
  // Register writes
  // Timer and status offsets are read-only; writes there are dropped
  assign wr_mask = reg_wr && (reg_addr == `TTM_OFS_MASK_TWO);
  assign wr_config_three = reg_wr && (reg_addr == `TTM_OFS_CONFIG_THREE);
  assign wr_config_four = reg_wr && (reg_addr == `TTM_OFS_CONFIG_FOUR);
  assign wr_limit = reg_wr && (reg_addr == `TTM_OFS_LIMIT);

  // Each strobe is one cycle wide, so one write lands per access
  always @* begin
    mask_two_nxt = mask_two_r;
    config_three_nxt = config_three_r;
    config_four_nxt = config_four_r;
    limit_nxt = limit_r;
    if (wr_mask)
      mask_two_nxt = reg_wdata;
    if (wr_config_three)
      config_three_nxt = reg_wdata;
    if (wr_config_four)
      config_four_nxt = reg_wdata;
    if (wr_limit)
      limit_nxt = reg_wdata;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mask_two_r <= `TTM_RST_BYTE;
      config_three_r <= `TTM_RST_BYTE;
      config_four_r <= `TTM_RST_BYTE;
      limit_r <= `TTM_RST_BYTE;
    end else begin
      mask_two_r <= mask_two_nxt;
      config_three_r <= config_three_nxt;
      config_four_r <= config_four_nxt;
      limit_r <= limit_nxt;
    end
  end

  // ==========================================================
  // Assertion timer
  // Bit0 marks any assertion; the first whole LSB period is absorbed
  // so bit1 shows only once two periods of asserted time have passed
  // A read mid-assertion restarts at one, the line still being active
  assign tick_last = (tick_r >= LSB_CYCLES - 1);
  always @* begin
    timer_nxt = timer_r;
    tick_nxt = tick_r;
    seen_nxt = seen_r;
    wrapped_nxt = wrapped_r;
    if (rd_timer) begin
      timer_nxt = `TTM_RST_BYTE;
      tick_nxt = 32'h00000000;
      seen_nxt = 1'b0;
      wrapped_nxt = 1'b0;
      if (thermal_throttle_line) begin
        timer_nxt = `TTM_ONE;
        seen_nxt = 1'b1;
      end
    end else if (thermal_throttle_line) begin
      if (!seen_r) begin
        seen_nxt = 1'b1;
        if (timer_r == `TTM_RST_BYTE)
          timer_nxt = `TTM_ONE;
      end
      if (timer_r != `TTM_FULL_SCALE) begin
        if (tick_last) begin
          tick_nxt = 32'h00000000;
          wrapped_nxt = 1'b1;
          // Tick sum survives pauses, so asserted time really accumulates
          if (wrapped_r)
            timer_nxt = timer_r + `TTM_ONE;
        end else begin
          tick_nxt = tick_r + 32'h00000001;
        end
      end
    end
  end

  // All timer state moves together on every clock
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_r <= `TTM_RST_BYTE;
      tick_r <= 32'h00000000;
      seen_r <= 1'b0;
      wrapped_r <= 1'b0;
    end else begin
      timer_r <= timer_nxt;
      tick_r <= tick_nxt;
      seen_r <= seen_nxt;
      wrapped_r <= wrapped_nxt;
    end
  end

  // ==========================================================
  // Limit compare and sticky flag
  // Zero limit trips as soon as bit0 shows; limit one needs count above one
  assign over_limit = (timer_r > limit_r);
  // Set beats a coincident status read, so no limit event is lost
  always @* begin
    flag_nxt = limit_exceeded_flag_r;
    if (over_limit)
      flag_nxt = 1'b1;
    else if (rd_status)
      flag_nxt = 1'b0;
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      limit_exceeded_flag_r <= 1'b0;
    end else begin
      limit_exceeded_flag_r <= flag_nxt;
    end
  end

  // ==========================================================
  // Read data
  // Data is captured on the strobe and stands until the next read
  always @* begin
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `TTM_OFS_MASK_TWO: rdata_nxt = mask_two_r;
        `TTM_OFS_CONFIG_THREE: rdata_nxt = config_three_r;
        `TTM_OFS_TIMER: rdata_nxt = timer_r;
        `TTM_OFS_LIMIT: rdata_nxt = limit_r;
        `TTM_OFS_CONFIG_FOUR: rdata_nxt = config_four_r;
        `TTM_OFS_STATUS_TWO: begin
          // Only the thermal limit bit exists; the rest read as zero
          rdata_nxt = `TTM_RST_BYTE;
          rdata_nxt[`TTM_FLAG_BIT] = limit_exceeded_flag_r;
        end
        // Unmapped offsets read as zero
        default: rdata_nxt = `TTM_RST_BYTE;
      endcase
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `TTM_RST_BYTE;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Alert, tach release and fan boost
  // A fan counts as running in auto mode above start, or in manual with duty
  generate
    for (g = 0; g < FANS; g = g + 1) begin : g_run
      assign fan_running[g] = fan_auto_mode[g] ? fan_above_start[g] :
        (fan_duty_in[g*8 +: 8] != `TTM_RST_BYTE);
    end
  endgenerate
  assign boost_on = config_three_r[`TTM_C3_BOOST_BIT] & thermal_throttle_line;
  // Mask only hides the alert; the flag itself is still set
  assign alert_req = config_four_r[`TTM_C4_ALERT_BIT] & limit_exceeded_flag_r &
    ~mask_two_r[`TTM_FLAG_BIT];

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      alert_out_n <= 1'b1;
      alert_out_en <= 1'b0;
      fourth_tach_input_en <= 1'b0;
      fan_duty_out <= {FANS*8{1'b0}};
    end else begin
      alert_out_en <= config_four_r[`TTM_C4_ALERT_BIT];
      // Open-drain style: drive low only while an unmasked alert is pending
      alert_out_n <= ~alert_req;
      fourth_tach_input_en <= mon_en & high_sel;
      // Boost overrides only fans that already spin
      for (i = 0; i < FANS; i = i + 1) begin
        if (boost_on && fan_running[i])
          fan_duty_out[i*8 +: 8] <= `TTM_FULL_SCALE;
        else
          fan_duty_out[i*8 +: 8] <= fan_duty_in[i*8 +: 8];
      end
    end
  end
endmodule // ttm_monitor
`default_nettype wire

// [bench/ttm_partner.sv]
// Model of the far-side hot output driving the two thermal pins.
// Assumes the bench commands the hot level and which pin is wired.
`default_nettype none
module ttm_partner (
  // Command
  input wire logic hot,
  input wire logic alt,
  // Pins, active low, pulled up when released
  output logic pin_def_n,
  output logic pin_alt_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {pin_def_n, pin_alt_n} = 2'b11;
  // Skewed off the clock edge so the input really is asynchronous
  always @(hot or alt) #37 {pin_def_n, pin_alt_n} = {!(hot && !alt), !(hot && alt)};
endmodule // ttm_partner
`default_nettype wire

// [bench/ttm_monitor_assertions.sv]
// Port checker for the thermal input timer monitor.
// Assumes it is bound into every ttm_monitor instance.
`default_nettype none
module ttm_monitor_assertions #(parameter FANS = 3) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Fans and alert
  input wire [FANS*8-1:0] fan_duty_in,
  input wire [FANS*8-1:0] fan_duty_out,
  input wire alert_out_n,
  input wire alert_out_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire [7:0] f_in = fan_duty_in[7:0];
  wire [7:0] f_out = fan_duty_out[7:0];
  sequence s_at(st, a); st && reg_addr == a; endsequence
  sequence s_q2; (!reg_rd && !reg_wr) [*2]; endsequence
  a_alert_needs_en: assert property (!alert_out_n |-> alert_out_en)
    else $error("alert while disabled");
  a_en_follows: assert property (s_at(reg_wr, 8'h7D) ##1 s_q2 |->
    alert_out_en == $past(reg_wdata[0], 2)) else $error("alert enable wrong");
  a_fan_follows: assert property ($past(rstn) && f_out != 8'hFF |-> f_out == $past(f_in))
    else $error("fan duty altered");
  a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_timer_clears: assert property (s_at(reg_rd, 8'h79) ##[1:3] s_at(reg_rd, 8'h79)
    |=> reg_rdata <= 8'h01) else $error("timer not cleared");
  a_status_bits: assert property (s_at(reg_rd, 8'h42) |=> (reg_rdata & 8'hDF) == 8'h00)
    else $error("stray status bits");
  a_unmapped_zero: assert property (s_at(reg_rd, 8'h00) |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  a_alert_release: assert property ($rose(alert_out_n) |-> $past(reg_rd || reg_wr, 2))
    else $error("alert released alone");
endmodule // ttm_monitor_assertions
bind ttm_monitor ttm_monitor_assertions #(.FANS(FANS)) u_chk (.sys_clk, .rstn, .reg_wr,
  .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .fan_duty_in, .fan_duty_out, .alert_out_n,
  .alert_out_en);
`default_nettype wire

// [bench/ttm_monitor_tb.sv]
// Register-level tests of the thermal input timer monitor against the pin model.
// Assumes design, pin model and checker are compiled before this file.
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: %h not %h", $time, g, e); end end
module ttm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick so saturation takes a few thousand cycles
  localparam LSB = 8;
  logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hot = 1'b0, alt = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [23:0] duty = 24'h000000;
  logic [2:0] amode = 3'b000, above = 3'b000;
  wire [7:0] reg_rdata;
  wire [23:0] fan_out;
  wire pd_n, pa_n, tach_en, al_n, al_en;
  int n_fail = 0, num_checks = 0;
  ttm_partner hotsrc (.hot(hot), .alt(alt), .pin_def_n(pd_n), .pin_alt_n(pa_n));
  ttm_monitor #(.LSB_CYCLES(LSB), .FANS(3)) dut (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .thermal_throttle_line_pin_default_n(pd_n), .thermal_throttle_line_pin_alt_n(pa_n),
    .fan_duty_in(duty), .fan_auto_mode(amode), .fan_above_start(above), .fan_duty_out(fan_out),
    .fourth_tach_input_en(tach_en), .alert_out_n(al_n), .alert_out_en(al_en));
  // One strobe cycle; read data is settled one cycle later
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge sys_clk);
    if (!w) `CHK(reg_rdata, d)
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial forever #50 sys_clk = ~sys_clk;
  // Tests need about 2300 cycles
  initial begin
    #1000000;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    `CHK(al_en, 1'b0)
    acc(1'b0, 8'h00, 8'h00);
    duty <= 24'h300040;
    amode <= 3'b100;
    acc(1'b1, 8'h78, 8'h06);
    acc(1'b1, 8'h7A, 8'h01);
    acc(1'b1, 8'h7D, 8'h01);
    @(posedge sys_clk);
    `CHK(al_en, 1'b1)
    hot <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK(fan_out, 24'h3000FF)
    repeat (LSB - 4) @(posedge sys_clk);
    hot <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK(al_n, 1'b1)
    hot <= 1'b1;
    repeat (LSB + 2) @(posedge sys_clk);
    hot <= 1'b0;
    repeat (5) @(posedge sys_clk);
    `CHK(al_n, 1'b0)
    acc(1'b0, 8'h42, 8'h20);
    acc(1'b0, 8'h79, 8'h02);
    acc(1'b0, 8'h79, 8'h00);
    acc(1'b0, 8'h42, 8'h20);
    acc(1'b0, 8'h42, 8'h00);
    $display("test accumulate done");
    acc(1'b1, 8'h75, 8'h20);
    acc(1'b1, 8'h7A, 8'h00);
    hot <= 1'b1;
    repeat (5) @(posedge sys_clk);
    acc(1'b0, 8'h79, 8'h01);
    acc(1'b0, 8'h79, 8'h01);
    acc(1'b0, 8'h42, 8'h20);
    `CHK(al_n, 1'b1)
    repeat (LSB * 263) @(posedge sys_clk);
    acc(1'b0, 8'h79, 8'hFF);
    $display("test limit done");
    hot <= 1'b0;
    alt <= 1'b1;
    acc(1'b1, 8'h78, 8'h00);
    acc(1'b1, 8'h7D, 8'h03);
    acc(1'b0, 8'h79, 8'h01);
    hot <= 1'b1;
    repeat (20) @(posedge sys_clk);
    acc(1'b0, 8'h79, 8'h00);
    acc(1'b1, 8'h78, 8'h02);
    repeat (6) @(posedge sys_clk);
    `CHK(tach_en, 1'b1)
    `CHK(fan_out, 24'h300040)
    acc(1'b0, 8'h79, 8'h01);
    // Hot now on the unselected pin only
    alt <= 1'b0;
    repeat (20) @(posedge sys_clk);
    acc(1'b0, 8'h79, 8'h01);
    $display("test pins done");
    final_report;
  end
endmodule // ttm_monitor_tb
`default_nettype wire
